// >>> hw/ubl_consts.svh
`ifndef UBL_CONSTS_SVH
`define UBL_CONSTS_SVH
`define UBL_MATCH     8'h5a
`define UBL_BAUD_ERR  8'h62
`define UBL_CMD_ERR   8'h63
`define UBL_FRAME_ERR 8'ha1
`define UBL_OVR_ERR   8'ha3
`define UBL_CMD_RAM   8'h60
`define UBL_CMD_FSUM  8'h90
`define UBL_START     8'h3a
`define UBL_REC_DATA  8'h00
`define UBL_REC_EOF   8'h01
`define UBL_REC_EXT   8'h02
`define UBL_EXT_LEN   8'h02
`define UBL_INIT_BAUD 8'h28
`define UBL_VEC_LO    16'hffe0
`define UBL_VEC_HI    16'hffff
`define UBL_FLASH_LO  16'h1000
`define UBL_FLASH_HI  16'hffff
`endif

// >>> hw/ubl_loader.sv
`timescale 1ns/1ps
`include "ubl_consts.svh"
module ubl_loader
	import ubl_pkg::*;
#(
	parameter int         NBAUD              = 6,
	parameter logic [7:0] BAUD_CODES [NBAUD] = '{8'h28, 8'h18, 8'h06, 8'h03, 8'h02, 8'h01},
	parameter logic [15:0] FLASH_LO          = `UBL_FLASH_LO
)(
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// Received bytes
	input  wire ubl_rx_t     rx_i,
	// Transmit handshake
	input  wire logic        tx_ready_i,
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	// Rate control
	output logic [7:0]       baud_sel_o,
	output logic             autobaud_o,
	// Memory read port
	output logic             mem_rd_o,
	output logic [15:0]      mem_addr_o,
	input  wire logic [7:0]  mem_rdata_i,
	// RAM write port
	output ubl_ram_t         ram_o,
	// Status and jump
	output logic             halted_o,
	output logic             jump_o,
	output logic [15:0]      jump_addr_o
);

	ubl_state_t s_reg;
	ubl_state_t s_next;
	logic [NBAUD-1:0] baud_hit;
	logic rx_ok;
	logic rx_bad;
	logic [7:0] err_code;
	logic [7:0] ck_sum;

	// ------------------------------------------------------------
	// Rate code lookup
	// ------------------------------------------------------------
	for (genvar g = 0; g < NBAUD; g++)
	begin : g_baud
		assign baud_hit[g] = (rx_i.data == BAUD_CODES[g]);
	end

	assign rx_ok    = rx_i.valid && !rx_i.ferr && !rx_i.oerr;
	assign rx_bad   = rx_i.valid && (rx_i.ferr || rx_i.oerr);
	assign err_code = rx_i.ferr ? `UBL_FRAME_ERR : `UBL_OVR_ERR;
	assign ck_sum   = s_reg.ck + rx_i.data;

	function automatic ubl_state_t send(ubl_state_t x, logic [7:0] d, logic [1:0] c, ubl_st_t r, logic sm);
		ubl_state_t y;
		y         = x;
		y.tx_v    = 1'b1;
		y.tx_d    = d;
		y.tx_left = c;
		y.ret     = r;
		y.tx_sum  = sm;
		y.st      = S_SEND;
		return y;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_next        = s_reg;
		s_next.mem_rd = 1'b0;
		s_next.ram.we = 1'b0;
		s_next.jump   = 1'b0;
		case (s_reg.st)
			S_MATCH:
				if (rx_ok && rx_i.data == `UBL_MATCH)
					s_next = send(s_reg, `UBL_MATCH, 2'd1, S_BAUD, 1'b0);
			S_BAUD:
				if (rx_bad)
					s_next = send(s_reg, err_code, 2'd3, S_HALT, 1'b0);
				else if (rx_ok && |baud_hit)
				begin
					s_next       = send(s_reg, rx_i.data, 2'd1, S_CMD, 1'b0);
					s_next.bpend = rx_i.data;
				end
				else if (rx_ok)
					s_next = send(s_reg, `UBL_BAUD_ERR, 2'd3, S_HALT, 1'b0);
			S_CMD:
				if (rx_bad)
					s_next = send(s_reg, err_code, 2'd3, S_HALT, 1'b0);
				else if (rx_ok && rx_i.data == `UBL_CMD_RAM)
				begin
					s_next       = send(s_reg, rx_i.data, 2'd1, S_PWA, 1'b0);
					s_next.idx   = 2'd0;
					s_next.sum   = 16'h0000;
					s_next.first = 1'b0;
				end
				else if (rx_ok && rx_i.data == `UBL_CMD_FSUM)
				begin
					s_next       = send(s_reg, rx_i.data, 2'd1, S_FSUM, 1'b0);
					s_next.mem_a = FLASH_LO;
					s_next.sum   = 16'h0000;
					s_next.ph    = 2'd0;
				end
				else if (rx_ok)
					s_next = send(s_reg, `UBL_CMD_ERR, 2'd3, S_HALT, 1'b0);
			S_PWA:
				if (rx_bad)
					s_next.st = S_HALT;
				else if (rx_ok)
				begin
					s_next.pwa = {s_reg.pwa[23:0], rx_i.data};
					s_next.idx = s_reg.idx + 2'd1;
					if (s_reg.idx == 2'd3)
					begin
						s_next.st    = S_BLANK;
						s_next.mem_a = `UBL_VEC_LO;
						s_next.b0    = 1'b1;
						s_next.bf    = 1'b1;
						s_next.ph    = 2'd0;
					end
				end
			S_BLANK, S_PWCNT, S_PWCMP, S_FSUM:
				if (s_reg.ph == 2'd0)
				begin
					s_next.mem_rd = 1'b1;
					s_next.ph     = 2'd1;
				end
				else if (s_reg.ph == 2'd1)
					s_next.ph = 2'd2;
				else
				begin
					s_next.ph = 2'd0;
					case (s_reg.st)
						S_BLANK:
						begin
							s_next.b0    = s_reg.b0 && mem_rdata_i == 8'h00;
							s_next.bf    = s_reg.bf && mem_rdata_i == 8'hff;
							s_next.mem_a = s_reg.mem_a + 16'h0001;
							if (s_reg.mem_a == `UBL_VEC_HI)
							begin
								s_next.mem_a = s_reg.pwa[31:16];
								s_next.st    = (s_next.b0 || s_next.bf) ? S_HSTART : S_PWCNT;
							end
						end
						S_PWCNT:
						begin
							s_next.cnt   = mem_rdata_i;
							s_next.mem_a = s_reg.pwa[15:0];
							s_next.st    = (mem_rdata_i == 8'h00) ? S_HSTART : S_PWRX;
						end
						S_PWCMP:
							if (mem_rdata_i != s_reg.rxb)
								s_next.st = S_HALT;
							else
							begin
								s_next.cnt   = s_reg.cnt - 8'd1;
								s_next.mem_a = s_reg.mem_a + 16'h0001;
								s_next.st    = (s_reg.cnt == 8'd1) ? S_HSTART : S_PWRX;
							end
						default:
						begin
							s_next.sum   = s_reg.sum + {8'h00, mem_rdata_i};
							s_next.mem_a = s_reg.mem_a + 16'h0001;
							if (s_reg.mem_a == `UBL_FLASH_HI)
								s_next = send(s_next, s_next.sum[15:8], 2'd2, S_CMD, 1'b1);
						end
					endcase
				end
			S_PWRX:
				if (rx_bad)
					s_next.st = S_HALT;
				else if (rx_ok)
				begin
					s_next.rxb = rx_i.data;
					s_next.st  = S_PWCMP;
				end
			S_HSTART, S_HLEN, S_HAH, S_HAL, S_HTYPE, S_HDATA, S_HCK:
				if (rx_bad)
					s_next.st = S_HALT;
				else if (rx_ok)
				begin
					s_next.ck = ck_sum;
					case (s_reg.st)
						S_HSTART:
						begin
							s_next.ck = 8'h00;
							if (rx_i.data == `UBL_START)
								s_next.st = S_HLEN;
						end
						S_HLEN:
						begin
							s_next.len = rx_i.data;
							s_next.st  = S_HAH;
						end
						S_HAH:
						begin
							s_next.mem_a[15:8] = rx_i.data;
							s_next.st          = S_HAL;
						end
						S_HAL:
						begin
							s_next.mem_a[7:0] = rx_i.data;
							s_next.st         = S_HTYPE;
						end
						S_HTYPE:
						begin
							s_next.rtype = rx_i.data;
							if (rx_i.data > `UBL_REC_EXT || (rx_i.data == `UBL_REC_EXT && s_reg.len != `UBL_EXT_LEN))
								s_next.st = S_HALT;
							else
								s_next.st = (s_reg.len == 8'h00) ? S_HCK : S_HDATA;
						end
						S_HDATA:
						begin
							if (s_reg.rtype == `UBL_REC_DATA)
							begin
								s_next.ram = '{we: 1'b1, addr: s_reg.mem_a, data: rx_i.data};
								s_next.sum = s_reg.sum + {8'h00, rx_i.data};
								if (!s_reg.first)
								begin
									s_next.first = 1'b1;
									s_next.faddr = s_reg.mem_a;
								end
							end
							s_next.mem_a = s_reg.mem_a + 16'h0001;
							s_next.len   = s_reg.len - 8'd1;
							if (s_reg.len == 8'd1)
								s_next.st = S_HCK;
						end
						default:
							if (ck_sum != 8'h00)
								s_next.st = S_HALT;
							else if (s_reg.rtype == `UBL_REC_EOF)
								s_next = send(s_next, s_reg.sum[15:8], 2'd2, S_JUMP, 1'b1);
							else
								s_next.st = S_HSTART;
					endcase
				end
			S_SEND:
				if (tx_ready_i)
				begin
					s_next.tx_left = s_reg.tx_left - 2'd1;
					if (s_reg.tx_sum)
						s_next.tx_d = s_reg.sum[7:0];
					if (s_reg.tx_left == 2'd1)
					begin
						s_next.tx_v = 1'b0;
						s_next.st   = s_reg.ret;
						if (s_reg.ret == S_CMD)
							s_next.baud = s_reg.bpend;
					end
				end
			S_JUMP:
			begin
				s_next.jump = 1'b1;
				s_next.st   = S_DONE;
			end
			default:
				s_next.st = s_reg.st;
		endcase
		s_next.autob  = (s_next.st == S_MATCH);
		s_next.halted = (s_next.st == S_HALT);
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_reg        <= '0;
			s_reg.st     <= S_MATCH;
			s_reg.ret    <= S_MATCH;
			s_reg.autob  <= 1'b1;
			s_reg.baud   <= `UBL_INIT_BAUD;
			s_reg.bpend  <= `UBL_INIT_BAUD;
		end
		else if (ce_i)
			s_reg <= s_next;
	end

	assign tx_valid_o  = s_reg.tx_v;
	assign tx_data_o   = s_reg.tx_d;
	assign baud_sel_o  = s_reg.baud;
	assign autobaud_o  = s_reg.autob;
	assign mem_rd_o    = s_reg.mem_rd;
	assign mem_addr_o  = s_reg.mem_a;
	assign ram_o       = s_reg.ram;
	assign halted_o    = s_reg.halted;
	assign jump_o      = s_reg.jump;
	assign jump_addr_o = s_reg.faddr;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence match_in;
		ce_i && s_reg.st == S_MATCH && rx_ok && rx_i.data == `UBL_MATCH;
	endsequence
	sequence echo_out;
		tx_valid_o && tx_data_o == `UBL_MATCH && s_reg.tx_left == 2'd1;
	endsequence
	match_echo_a: assert property (match_in |=> echo_out) else $error("match byte not echoed");
	cmd_error_a: assert property (ce_i && s_reg.st == S_CMD && rx_ok && rx_i.data != `UBL_CMD_RAM
		&& rx_i.data != `UBL_CMD_FSUM |=> tx_data_o == `UBL_CMD_ERR && s_reg.tx_left == 2'd3
		&& s_reg.ret == S_HALT) else $error("command error reply wrong");
	frame_err_a: assert property (ce_i && s_reg.st == S_CMD && rx_i.valid && rx_i.ferr
		|=> tx_data_o == `UBL_FRAME_ERR && s_reg.tx_left == 2'd3) else $error("framing reply wrong");
	hex_quiet_a: assert property (s_reg.st inside {[S_HSTART:S_HCK]} |-> !tx_valid_o)
		else $error("hex byte echoed");
	halt_quiet_a: assert property (halted_o |=> halted_o && !tx_valid_o && !ram_o.we && !mem_rd_o)
		else $error("halted block active");
	pw_miss_a: assert property (ce_i && s_reg.st == S_PWCMP && s_reg.ph == 2'd2 && mem_rdata_i != s_reg.rxb
		|=> halted_o && !tx_valid_o) else $error("password mismatch not halted");
	ram_store_a: assert property (ce_i && s_reg.st == S_HDATA && rx_ok && s_reg.rtype == `UBL_REC_DATA
		|=> ram_o.we && ram_o.data == $past(rx_i.data) && ram_o.addr == $past(s_reg.mem_a))
		else $error("RAM store wrong");
	sum_hi_a: assert property (tx_valid_o && s_reg.tx_sum && s_reg.tx_left == 2'd2 |-> tx_data_o == s_reg.sum[15:8])
		else $error("sum upper byte wrong");
	jump_go_a: assert property (ce_i && s_reg.st == S_JUMP |=> jump_o && !tx_valid_o && jump_addr_o == $past(jump_addr_o))
		else $error("jump not issued");
	rate_hold_a: assert property (s_reg.st inside {S_MATCH, S_BAUD} |-> baud_sel_o == `UBL_INIT_BAUD)
		else $error("rate changed early");

endmodule

// >>> hw/ubl_pkg.sv
package ubl_pkg;
	typedef enum logic [4:0] {
		S_MATCH = 5'b00000, S_BAUD = 5'b00001, S_CMD = 5'b00010, S_PWA = 5'b00011,
		S_BLANK = 5'b00100, S_PWCNT = 5'b00101, S_PWRX = 5'b00110, S_PWCMP = 5'b00111,
		S_HSTART = 5'b01000, S_HLEN = 5'b01001, S_HAH = 5'b01010, S_HAL = 5'b01011,
		S_HTYPE = 5'b01100, S_HDATA = 5'b01101, S_HCK = 5'b01110, S_FSUM = 5'b01111,
		S_SEND = 5'b10000, S_JUMP = 5'b10001, S_DONE = 5'b10010, S_HALT = 5'b10011
	} ubl_st_t;
	typedef struct packed {
		logic       valid;
		logic       ferr;
		logic       oerr;
		logic [7:0] data;
	} ubl_rx_t;
	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  data;
	} ubl_ram_t;
	typedef struct packed {
		ubl_st_t     st;
		ubl_st_t     ret;
		logic        tx_v;
		logic [7:0]  tx_d;
		logic [1:0]  tx_left;
		logic        tx_sum;
		logic [7:0]  baud;
		logic [7:0]  bpend;
		logic        autob;
		logic        halted;
		logic [31:0] pwa;
		logic [1:0]  idx;
		logic [1:0]  ph;
		logic        mem_rd;
		logic [15:0] mem_a;
		logic        b0;
		logic        bf;
		logic [7:0]  cnt;
		logic [7:0]  rxb;
		logic [7:0]  len;
		logic [7:0]  rtype;
		logic [7:0]  ck;
		logic [15:0] sum;
		logic        first;
		logic [15:0] faddr;
		logic        jump;
		ubl_ram_t    ram;
	} ubl_state_t;
endpackage

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "ubl_consts.svh"
module testbench
	import ubl_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        ce_i = 1'b1;
	ubl_rx_t     rx_i;
	logic        tx_ready_i;
	logic        tx_valid_o;
	logic [7:0]  tx_data_o;
	logic [7:0]  baud_sel_o;
	logic        autobaud_o;
	logic        mem_rd_o;
	logic [15:0] mem_addr_o;
	logic [7:0]  mem_rdata_i;
	ubl_ram_t    ram_o;
	logic        halted_o;
	logic        jump_o;
	logic [15:0] jump_addr_o;
	ubl_ram_t    wr_q [$];
	int          jumps;
	int          bad_count = 0;
	int          checks_done = 0;
	always #50 clk_i = ~clk_i;
	ubl_loader #(.FLASH_LO(16'hffe0)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .rx_i(rx_i),
		.tx_ready_i(tx_ready_i),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .baud_sel_o(baud_sel_o), .autobaud_o(autobaud_o),
		.mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i), .ram_o(ram_o),
		.halted_o(halted_o), .jump_o(jump_o), .jump_addr_o(jump_addr_o));
	ubl_host_model host (.clk_i(clk_i), .rx_o(rx_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.tx_ready_o(tx_ready_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));
	always @(negedge clk_i)
	begin
		if (ram_o.we === 1'b1)
			wr_q.push_back(ram_o);
		if (jump_o === 1'b1)
			jumps++;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask
	task automatic stop_test;
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic restart(input logic blank);
		@(posedge clk_i);
		#1 nrst_i = 1'b0;
		host.blank = blank;
		host.slow = 1'b0;
		host.got_q.delete();
		wr_q.delete();
		jumps = 0;
		repeat (10) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		chk1("autobaud", 1'b1, autobaud_o);
	endtask
	task automatic expect_tx(input logic [7:0] exp);
		for (int n = 0; n < 2000 && host.got_q.size() == 0; n++)
			@(negedge clk_i);
		chk("tx byte", {8'h00, exp}, {8'h00, host.got_q.size() ? host.got_q.pop_front() : 8'hxx});
	endtask
	task automatic quiet(input int n);
		repeat (n) @(negedge clk_i);
		chk("tx count", 16'h0000, 16'(host.got_q.size()));
	endtask
	task automatic send_all(input logic [7:0] bs [$]);
		foreach (bs[i])
			host.send(bs[i]);
	endtask
	task automatic hello(input logic [7:0] rate, input logic [7:0] cmd, input logic fe = 1'b0, input logic oe = 1'b0);
		host.send(`UBL_MATCH);
		expect_tx(`UBL_MATCH);
		host.send(rate);
		expect_tx(rate);
		chk("baud", {8'h00, rate}, {8'h00, baud_sel_o});
		host.send(cmd, fe, oe);
	endtask
	task automatic open_ram;
		hello(`UBL_INIT_BAUD, `UBL_CMD_RAM);
		expect_tx(`UBL_CMD_RAM);
		send_all({8'h00, 8'h10, 8'h00, 8'h20});
		quiet(200);
	endtask
	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	task automatic t_rate_err;
		restart(1'b1);
		host.send(`UBL_MATCH);
		expect_tx(`UBL_MATCH);
		host.send(8'h55);
		repeat (3) expect_tx(`UBL_BAUD_ERR);
		quiet(20);
		chk1("halted", 1'b1, halted_o);
		host.send(`UBL_MATCH);
		quiet(40);
	endtask
	task automatic t_cmd_err;
		restart(1'b1);
		host.slow = 1'b1;
		hello(8'h18, 8'h33);
		repeat (3) expect_tx(`UBL_CMD_ERR);
		quiet(20);
		chk1("halted", 1'b1, halted_o);
	endtask
	task automatic t_rx_err(input logic fe, input logic oe, input logic [7:0] code);
		restart(1'b1);
		hello(`UBL_INIT_BAUD, `UBL_CMD_RAM, fe, oe);
		repeat (3) expect_tx(code);
		quiet(20);
		chk1("halted", 1'b1, halted_o);
	endtask
	task automatic t_ram;
		restart(1'b1);
		open_ram();
		send_all({8'h11, 8'h3a, 8'h02, 8'h01, 8'h00, 8'h00, 8'h12, 8'h34, 8'hb7, 8'h0d});
		quiet(20);
		@(posedge clk_i);
		#1 ce_i = 1'b0;
		send_all({8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
		quiet(20);
		@(posedge clk_i);
		#1 ce_i = 1'b1;
		host.slow = 1'b1;
		send_all({8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
		expect_tx(8'h00);
		expect_tx(8'h46);
		for (int n = 0; n < 20 && jumps == 0; n++)
			@(negedge clk_i);
		chk1("jump", 1'b1, jumps == 1);
		chk("jump addr", 16'h0100, jump_addr_o);
		chk("writes", 16'h0002, 16'(wr_q.size()));
		chk("ram addr", 16'h0100, wr_q[0].addr);
		chk("ram data", 16'h0012, {8'h00, wr_q[0].data});
		chk("ram addr", 16'h0101, wr_q[1].addr);
		chk("ram data", 16'h0034, {8'h00, wr_q[1].data});
	endtask
	task automatic t_bad_ck;
		restart(1'b1);
		open_ram();
		send_all({8'h3a, 8'h01, 8'h02, 8'h00, 8'h00, 8'h55, 8'h00});
		send_all({8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
		quiet(60);
		chk1("halted", 1'b1, halted_o);
	endtask
	task automatic t_pw(input logic [7:0] pw, input logic halt);
		restart(1'b0);
		open_ram();
		host.send(pw);
		quiet(40);
		chk1("halted", halt, halted_o);
	endtask
	task automatic t_fsum;
		restart(1'b1);
		hello(`UBL_INIT_BAUD, `UBL_CMD_FSUM);
		expect_tx(`UBL_CMD_FSUM);
		expect_tx(8'h1f);
		expect_tx(8'he0);
		quiet(20);
		host.send(`UBL_CMD_FSUM);
		expect_tx(`UBL_CMD_FSUM);
	endtask
	initial
	begin
		#2_000_000;
		bad_count++;
		stop_test();
	end
	initial
	begin
		t_rate_err();
		t_cmd_err();
		t_rx_err(1'b1, 1'b0, `UBL_FRAME_ERR);
		t_rx_err(1'b0, 1'b1, `UBL_OVR_ERR);
		t_ram();
		t_bad_ck();
		t_pw(8'h00, 1'b1);
		t_pw(8'hc3, 1'b0);
		t_fsum();
		stop_test();
	end
endmodule

// >>> testbench/ubl_host_model.sv
`timescale 1ns/1ps
module ubl_host_model
	import ubl_pkg::*;
(
	// Clock
	input  wire logic        clk_i,
	// Serial side
	output ubl_rx_t          rx_o,
	input  wire logic        tx_valid_i,
	input  wire logic [7:0]  tx_data_i,
	output logic             tx_ready_o,
	// Memory side
	input  wire logic        mem_rd_i,
	input  wire logic [15:0] mem_addr_i,
	output logic [7:0]       mem_rdata_o
);
	logic [7:0] got_q [$];
	logic       slow  = 1'b0;
	logic       blank = 1'b1;
	initial
	begin
		rx_o = '0;
		tx_ready_o = 1'b1;
		mem_rdata_o = 8'h00;
	end
	// Sends one byte as a one-cycle strobe, then lets the data line change.
	task automatic send(input logic [7:0] b, input logic fe = 1'b0, input logic oe = 1'b0);
		@(posedge clk_i);
		#1 rx_o = '{1'b1, fe, oe, b};
		@(posedge clk_i);
		#1 rx_o = '{1'b0, 1'b0, 1'b0, ~b};
		repeat (6) @(posedge clk_i);
	endtask
	// Takes transmitted bytes, stalling every other cycle in slow mode.
	always @(posedge clk_i)
	begin
		if (tx_valid_i && tx_ready_o)
			got_q.push_back(tx_data_i);
		tx_ready_o <= #1 slow ? ~tx_ready_o : 1'b1;
	end
	// Read data stands in the cycle after the request; otherwise it keeps changing.
	always @(posedge clk_i)
	begin
		mem_rdata_o <= #1 mem_rd_i ? (blank ? 8'hff : (mem_addr_i == 16'h0010 ? 8'h01 : 8'hc3)) : ~mem_rdata_o;
	end
endmodule
